// ===== inc/evgate_pkg.sv
package evgate_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CHAN_OFS = 8'h04;
    localparam logic [7:0] THRESH_OFS = 8'h08;
    localparam logic [7:0] LOWER_OFS = 8'h0C;
    localparam logic [7:0] UPPER_OFS = 8'h10;
    localparam logic [7:0] DELAY_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] BIN_ADDR_OFS = 8'h1C;
    localparam logic [7:0] BIN_DATA_OFS = 8'h20;
    // Control field positions
    localparam int CTRL_GATE_EN_BIT = 0;
    localparam int CTRL_GATE_HIGH_BIT = 1;
    localparam int CTRL_SORT_BIT = 2;
    localparam int CTRL_LFR_BIT = 3;
    localparam int CTRL_CLEAR_BIT = 4;
    // Reset values and channel count limits
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [14:0] CHAN_FULL_RST = 15'h1000;
    localparam logic [14:0] CHAN_REDUCED_RST = 15'h0400;
    localparam logic [14:0] CHAN_REDUCED_MAX = 15'h0800;
    localparam logic [14:0] CHAN_MIN = 15'h0080;
    localparam logic [14:0] CHAN_MAX = 15'h4000;
    localparam logic [9:0] THRESH_RST = 10'h000;
    localparam logic [13:0] LOWER_RST = 14'h0000;
    // Threshold is in 0.1 percent steps of full range
    localparam int THRESH_SCALE = 1000;
    // Gate delay limit and cycle conversion
    localparam int DELAY_MAX_US = 25;
    localparam int CLK_MHZ = 100;
    localparam int DELAY_MAX_CYC = DELAY_MAX_US * CLK_MHZ;
endpackage : evgate_pkg

// ===== src/spectrum_event_gating.sv
// Functional notes
// - Channel count selectable 128 to 16384
// - Default 4k; reduced 1k, max 2k
// - Drop events below percent threshold
// - Threshold is zero after reset
// - Count only channels within discriminator window
// - Lower default zero, upper count minus one
// - Software enables external gate use
// - Software selects gate active level
// - Sample gate delayed after pulse rise
// - Discard or sort gated-out events
// - Selectable triple differentiating filter mode
// - Filter mode off; absent on reduced
`timescale 1ns/1ps
module spectrum_event_gating #(
    parameter bit REDUCED = 1'b0,
    parameter int AMP_W = 16,
    parameter int BIN_W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Pulse path from the spectroscopic filter
    input wire logic rise_i,
    input wire logic amp_valid_i,
    input wire logic [AMP_W-1:0] amp_i,
    // External gate pin
    input wire logic gate_i,
    // Filter mode select toward the spectroscopic filter
    output logic low_frequency_reject_filter_o,
    // Count strobe
    output logic count_o,
    output logic count_sorted_o
);
    localparam int NBINS = 16384;
    localparam logic [14:0] CHAN_DEF =
        REDUCED ? evgate_pkg::CHAN_REDUCED_RST : evgate_pkg::CHAN_FULL_RST;
    localparam logic [14:0] CHAN_TOP =
        REDUCED ? evgate_pkg::CHAN_REDUCED_MAX : evgate_pkg::CHAN_MAX;

    // Two spectra: main and sorted-out
    logic [BIN_W-1:0] spec_main [NBINS];
    logic [BIN_W-1:0] spec_sort [NBINS];

    // Software registers
    logic [4:0] ctrl_q, ctrl_d;
    logic [14:0] chan_q, chan_d;
    logic [9:0] thresh_q, thresh_d;
    logic [13:0] lower_q, lower_d, upper_q, upper_d;
    logic [11:0] delay_q, delay_d;
    logic [14:0] bin_addr_q, bin_addr_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;

    // Gate pin synchroniser, three stages; a change counts when 2 and 3 agree
    logic [2:0] gsync_q;
    logic gate_lvl_q, gate_lvl_d;

    // Delay timer and sampled decision
    logic [11:0] dly_cnt_q, dly_cnt_d;
    logic dly_run_q, dly_run_d;
    logic gate_ok_q, gate_ok_d;
    logic gate_done_q, gate_done_d;

    // Channel pipeline stage
    logic cnt_stb_q, cnt_stb_d;
    logic cnt_sort_sel_q, cnt_sort_sel_d;
    logic [13:0] cnt_ch_q, cnt_ch_d;
    // Bin clear sweep; bins power up unknown, so both spectra are zeroed
    logic [13:0] clr_idx_q, clr_idx_d;
    logic clr_run_q, clr_run_d;

    logic wb_req, wb_wr;
    logic [AMP_W+15:0] scaled;
    logic [13:0] chan_idx;
    logic [AMP_W+9:0] thr_lhs, thr_rhs;
    logic thr_pass, win_pass, gate_pass;

    assign wb_req = cyc_i && stb_i && !ack_q;
    assign wb_wr = wb_req && we_i && (sel_i == 4'hF);

    // Register writes and reads; answer one cycle after request
    always_comb begin
        ctrl_d = ctrl_q;
        chan_d = chan_q;
        thresh_d = thresh_q;
        lower_d = lower_q;
        upper_d = upper_q;
        delay_d = delay_q;
        bin_addr_d = bin_addr_q;
        ack_d = wb_req;
        rdat_d = rdat_q;
        // Clear bit is self clearing
        ctrl_d[evgate_pkg::CTRL_CLEAR_BIT] = 1'b0;
        if (wb_wr) begin
            unique case (adr_i)
                evgate_pkg::CTRL_OFS: begin
                    ctrl_d = dat_i[4:0];
                    if (REDUCED) begin
                        ctrl_d[evgate_pkg::CTRL_LFR_BIT] = 1'b0;
                    end
                end
                evgate_pkg::CHAN_OFS: begin
                    if (dat_i[14:0] >= evgate_pkg::CHAN_MIN && dat_i[14:0] <= CHAN_TOP) begin
                        chan_d = dat_i[14:0];
                        lower_d = evgate_pkg::LOWER_RST;
                        upper_d = 14'(dat_i[14:0] - 15'h0001);
                    end
                end
                evgate_pkg::THRESH_OFS: thresh_d = dat_i[9:0];
                evgate_pkg::LOWER_OFS: lower_d = dat_i[13:0];
                evgate_pkg::UPPER_OFS: upper_d = dat_i[13:0];
                evgate_pkg::DELAY_OFS: begin
                    // Delay clamps at the documented maximum
                    if (dat_i[11:0] > 12'(evgate_pkg::DELAY_MAX_CYC)) begin
                        delay_d = 12'(evgate_pkg::DELAY_MAX_CYC);
                    end else begin
                        delay_d = dat_i[11:0];
                    end
                end
                evgate_pkg::BIN_ADDR_OFS: bin_addr_d = dat_i[14:0];
                default: ;
            endcase
        end
        if (wb_req && !we_i) begin
            unique case (adr_i)
                evgate_pkg::CTRL_OFS: rdat_d = {27'h000_0000, ctrl_q};
                evgate_pkg::CHAN_OFS: rdat_d = {17'h0_0000, chan_q};
                evgate_pkg::THRESH_OFS: rdat_d = {22'h00_0000, thresh_q};
                evgate_pkg::LOWER_OFS: rdat_d = {18'h0_0000, lower_q};
                evgate_pkg::UPPER_OFS: rdat_d = {18'h0_0000, upper_q};
                evgate_pkg::DELAY_OFS: rdat_d = {20'h0_0000, delay_q};
                evgate_pkg::STATUS_OFS: rdat_d = {30'h0000_0000, clr_run_q, gate_lvl_q};
                evgate_pkg::BIN_ADDR_OFS: rdat_d = {17'h0_0000, bin_addr_q};
                evgate_pkg::BIN_DATA_OFS: begin
                    // Bit 14 of bin address picks the sorted spectrum
                    rdat_d = bin_addr_q[14] ? 32'(spec_sort[bin_addr_q[13:0]])
                                            : 32'(spec_main[bin_addr_q[13:0]]);
                end
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= evgate_pkg::CTRL_RST;
            chan_q <= CHAN_DEF;
            thresh_q <= evgate_pkg::THRESH_RST;
            lower_q <= evgate_pkg::LOWER_RST;
            upper_q <= 14'(CHAN_DEF - 15'h0001);
            delay_q <= 12'h000;
            bin_addr_q <= 15'h0000;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            chan_q <= chan_d;
            thresh_q <= thresh_d;
            lower_q <= lower_d;
            upper_q <= upper_d;
            delay_q <= delay_d;
            bin_addr_q <= bin_addr_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;
    assign low_frequency_reject_filter_o = ctrl_q[evgate_pkg::CTRL_LFR_BIT];

    // Gate synchroniser; first stage read only by the second
    always_comb begin
        gate_lvl_d = gate_lvl_q;
        if (gsync_q[1] == gsync_q[2]) begin
            gate_lvl_d = gsync_q[2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gsync_q <= 3'h0;
            gate_lvl_q <= 1'b0;
        end else begin
            gsync_q <= {gsync_q[1:0], gate_i};
            gate_lvl_q <= gate_lvl_d;
        end
    end

    // Delay timer: sample gate delay plus one cycles after the pulse rise
    always_comb begin
        dly_cnt_d = dly_cnt_q;
        dly_run_d = dly_run_q;
        gate_ok_d = gate_ok_q;
        gate_done_d = gate_done_q;
        if (rise_i) begin
            dly_cnt_d = delay_q;
            dly_run_d = 1'b1;
            gate_done_d = 1'b0;
        end else if (dly_run_q) begin
            if (dly_cnt_q == 12'h000) begin
                gate_ok_d = (gate_lvl_q == ctrl_q[evgate_pkg::CTRL_GATE_HIGH_BIT]);
                gate_done_d = 1'b1;
                dly_run_d = 1'b0;
            end else begin
                dly_cnt_d = dly_cnt_q - 12'h001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_cnt_q <= 12'h000;
            dly_run_q <= 1'b0;
            gate_ok_q <= 1'b0;
            gate_done_q <= 1'b0;
        end else begin
            dly_cnt_q <= dly_cnt_d;
            dly_run_q <= dly_run_d;
            gate_ok_q <= gate_ok_d;
            gate_done_q <= gate_done_d;
        end
    end

    // Amplitude scaling and qualification
    // scale to channel
    assign scaled = {16'h0000, amp_i} * {{(AMP_W-15){1'b0}}, chan_q};
    assign chan_idx = 14'(scaled[AMP_W+15:AMP_W]);
    assign thr_lhs = (AMP_W+10)'({10'h000, amp_i} * 26'(evgate_pkg::THRESH_SCALE));
    assign thr_rhs = (AMP_W+10)'({16'h0000, thresh_q} << AMP_W);
    assign thr_pass = thr_lhs >= thr_rhs;
    assign win_pass = (chan_idx >= lower_q) && (chan_idx <= upper_q);
    // gate enable; no sample taken counts as gated out
    assign gate_pass = !ctrl_q[evgate_pkg::CTRL_GATE_EN_BIT] || (gate_done_q && gate_ok_q);

    always_comb begin
        cnt_stb_d = 1'b0;
        cnt_sort_sel_d = 1'b0;
        cnt_ch_d = chan_idx;
        // Sweep after reset or clear; events during the sweep are lost
        clr_idx_d = clr_run_q ? clr_idx_q + 14'h0001 : 14'h0000;
        clr_run_d = (clr_run_q && clr_idx_q != 14'h3FFF) || ctrl_q[evgate_pkg::CTRL_CLEAR_BIT];
        if (ctrl_q[evgate_pkg::CTRL_CLEAR_BIT]) clr_idx_d = 14'h0000;
        if (amp_valid_i && thr_pass && win_pass && !clr_run_q) begin
            if (gate_pass) begin
                cnt_stb_d = 1'b1;
            end else if (ctrl_q[evgate_pkg::CTRL_SORT_BIT]) begin
                cnt_stb_d = 1'b1;
                cnt_sort_sel_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_stb_q <= 1'b0;
            cnt_sort_sel_q <= 1'b0;
            cnt_ch_q <= 14'h0000;
            clr_idx_q <= 14'h0000;
            clr_run_q <= 1'b1;
        end else begin
            clr_idx_q <= clr_idx_d;
            clr_run_q <= clr_run_d;
            cnt_stb_q <= cnt_stb_d;
            cnt_sort_sel_q <= cnt_sort_sel_d;
            cnt_ch_q <= cnt_ch_d;
        end
    end

    // Histogram memory; the sweep write comes last so a zero wins a collision
    // increment bin
    always_ff @(posedge clk_i) begin
        if (cnt_stb_q && !cnt_sort_sel_q) begin
            spec_main[cnt_ch_q] <= spec_main[cnt_ch_q] + 1'b1;
        end
        if (cnt_stb_q && cnt_sort_sel_q) begin
            spec_sort[cnt_ch_q] <= spec_sort[cnt_ch_q] + 1'b1;
        end
        if (clr_run_q) begin
            spec_main[clr_idx_q] <= {BIN_W{1'b0}};
            spec_sort[clr_idx_q] <= {BIN_W{1'b0}};
        end
    end

    assign count_o = cnt_stb_q && !cnt_sort_sel_q;
    assign count_sorted_o = cnt_stb_q && cnt_sort_sel_q;

    // Assertions
    count_window_a: assert property (@(posedge clk_i) disable iff (rst_i)
        amp_valid_i && !win_pass |=> !cnt_stb_q) else $error("count outside window");
    thresh_cut_a: assert property (@(posedge clk_i) disable iff (rst_i)
        amp_valid_i && !thr_pass |=> !cnt_stb_q) else $error("count below threshold");
    discard_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_q[evgate_pkg::CTRL_SORT_BIT] |=> !count_sorted_o) else $error("sorted in discard");
    gate_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        amp_valid_i && thr_pass && win_pass && !ctrl_q[0] && !clr_run_q |=> count_o)
        else $error("ungated lost");
    gate_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rise_i && delay_q == 12'h000 ##1 !rise_i |=> gate_done_q) else $error("gate late");
    chan_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        chan_q >= evgate_pkg::CHAN_MIN && chan_q <= CHAN_TOP) else $error("bad size");
    reduced_lfr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        REDUCED |-> !low_frequency_reject_filter_o) else $error("filter on reduced");
    reset_def_a: assert property (@(posedge clk_i)
        $past(rst_i) |-> thresh_q == 10'h000 && chan_q == CHAN_DEF) else $error("bad reset");
    upper_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(chan_q) |-> upper_q == 14'(chan_q - 15'h0001)) else $error("upper stale");
    size_default_a: assert property (@(posedge clk_i)
        $past(rst_i) |-> chan_q == CHAN_DEF) else $error("bad default");
    ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held");
    sort_cov: cover property (@(posedge clk_i) count_sorted_o);
    main_cov: cover property (@(posedge clk_i) count_o);
    gate_cov: cover property (@(posedge clk_i) gate_done_q && gate_ok_q);
endmodule : spectrum_event_gating

// ===== tb/pulse_source_model.sv
`timescale 1ns/1ps
module pulse_source_model (
    // Clock
    input wire logic clk_i,
    // Commands from the bench
    input wire logic fire_i,
    input wire logic [15:0] amp_set_i,
    input wire logic gate_a_i,
    input wire logic gate_b_i,
    // Pulse path and gate pin toward the block
    output logic rise_o,
    output logic amp_valid_o,
    output logic [15:0] amp_o,
    output logic gate_o
);
    // Frame position, -1 when idle
    int cnt = -1;
    // Last amplitude, inverted on the bus between strobes
    logic [15:0] last = 16'h0000;
    initial begin
        rise_o = 1'b0;
        amp_valid_o = 1'b0;
        amp_o = 16'hFFFF;
        gate_o = 1'b0;
    end
    // One pulse: gate settles first so the synchroniser has caught up before the
    // rise strobe, then the gate moves mid-way, amplitude well after the decision
    always @(posedge clk_i) begin
        rise_o <= 1'b0;
        amp_valid_o <= 1'b0;
        amp_o <= ~last;
        if (fire_i) begin
            cnt <= 0;
            gate_o <= gate_a_i;
        end else if (cnt >= 0) begin
            cnt <= cnt + 1;
            if (cnt == 8) rise_o <= 1'b1;
            if (cnt == 15) gate_o <= gate_b_i;
            if (cnt == 60) begin
                amp_valid_o <= 1'b1;
                amp_o <= amp_set_i;
                last <= amp_set_i;
                cnt <= -1;
            end
        end
    end
endmodule : pulse_source_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    // Clock, reset and bus master state
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0000_0000;
    // Design outputs
    logic [31:0] dat_o;
    logic ack_o, lfr_o, count_o, count_sorted_o;
    // Partner wiring
    logic fire = 1'b0;
    logic gate_a = 1'b0;
    logic gate_b = 1'b0;
    logic [15:0] amp_set = 16'h0000;
    logic rise, amp_valid, gate;
    logic [15:0] amp;
    // Score keeping
    int n_fail = 0;
    int checks = 0;
    int k;
    // Channel count writes and the value expected back; out-of-range sizes must be ignored
    logic [31:0] chan_w [5] = '{32'h0000_0080, 32'h0000_4000, 32'h0000_0064, 32'h0000_4001,
        32'h0000_1000};
    logic [31:0] chan_e [5] = '{32'h0000_0080, 32'h0000_4000, 32'h0000_4000, 32'h0000_4000,
        32'h0000_1000};

    always #5 clk_i = ~clk_i;

    spectrum_event_gating uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .rise_i(rise), .amp_valid_i(amp_valid), .amp_i(amp), .gate_i(gate),
        .low_frequency_reject_filter_o(lfr_o), .count_o(count_o),
        .count_sorted_o(count_sorted_o));

    pulse_source_model src (.clk_i(clk_i), .fire_i(fire), .amp_set_i(amp_set),
        .gate_a_i(gate_a), .gate_b_i(gate_b), .rise_o(rise), .amp_valid_o(amp_valid),
        .amp_o(amp), .gate_o(gate));

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Compare one value
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp

    // One classic cycle; held until ack is sampled, then released for a cycle
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int i;
        i = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 20);
        q = dat_o;
        if (i >= 20) begin
            n_fail++;
            wrap_up();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb_cycle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask : wr

    // Read and compare a register
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0000_0000, q);
        cmp(name, exp, q);
    endtask : rchk

    // Fire one pulse and count strobes on both spectra over a fixed window
    task automatic ev(input logic [15:0] a, input logic ga, input logic gb,
        input logic [31:0] ec, input logic [31:0] es);
        logic [31:0] nc, ns;
        nc = 0;
        ns = 0;
        fire <= 1'b1;
        amp_set <= a;
        gate_a <= ga;
        gate_b <= gb;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (80) begin
            @(posedge clk_i);
            #1;
            if (count_o === 1'b1) nc++;
            if (count_sorted_o === 1'b1) ns++;
        end
        @(posedge clk_i);
        cmp("main count", ec, nc);
        cmp("sorted count", es, ns);
    endtask : ev

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Power-up values
        rchk(evgate_pkg::CTRL_OFS, 32'h0000_0000, "ctrl");
        cmp("filter out", 32'h0000_0000, {31'h0000_0000, lfr_o});
        rchk(evgate_pkg::CHAN_OFS, 32'h0000_1000, "chan");
        rchk(evgate_pkg::THRESH_OFS, 32'h0000_0000, "thresh");
        rchk(evgate_pkg::LOWER_OFS, 32'h0000_0000, "lower");
        rchk(evgate_pkg::UPPER_OFS, 32'h0000_0FFF, "upper");
        rchk(8'h40, 32'h0000_0000, "unmapped");
        // Bins are zeroed by a sweep of one bin per cycle after reset
        rchk(evgate_pkg::STATUS_OFS, 32'h0000_0002, "sweep busy");
        repeat (16400) @(posedge clk_i);
        rchk(evgate_pkg::STATUS_OFS, 32'h0000_0000, "sweep done");
        // Mid-range pulse lands in channel 2048 of 4096
        ev(16'h8000, 1'b0, 1'b0, 32'h0000_0001, 32'h0000_0000);
        wr(evgate_pkg::BIN_ADDR_OFS, 32'h0000_0800);
        rchk(evgate_pkg::BIN_DATA_OFS, 32'h0000_0001, "bin 2048");
        // Channel sizes, including out-of-range writes that must be ignored
        for (k = 0; k < 5; k++) begin
            wr(evgate_pkg::CHAN_OFS, chan_w[k]);
            rchk(evgate_pkg::CHAN_OFS, chan_e[k], "chan size");
            rchk(evgate_pkg::UPPER_OFS, chan_e[k] - 1, "upper follow");
        end
        // Window 100..200, edges on both sides (amplitude 16 per channel)
        wr(evgate_pkg::LOWER_OFS, 32'h0000_0064);
        wr(evgate_pkg::UPPER_OFS, 32'h0000_00C8);
        ev(16'h0320, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
        ev(16'h0640, 1'b0, 1'b0, 32'h0000_0001, 32'h0000_0000);
        ev(16'h0C80, 1'b0, 1'b0, 32'h0000_0001, 32'h0000_0000);
        ev(16'h0C90, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
        // Threshold 5.0 percent cuts below channel 204.8
        wr(evgate_pkg::CHAN_OFS, 32'h0000_1000);
        wr(evgate_pkg::THRESH_OFS, 32'h0000_0032);
        ev(16'h0BB8, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
        ev(16'h0FA0, 1'b0, 1'b0, 32'h0000_0001, 32'h0000_0000);
        wr(evgate_pkg::THRESH_OFS, 32'h0000_0000);
        // Gate active high, then active low, discard handling
        wr(evgate_pkg::CTRL_OFS, 32'h0000_0003);
        ev(16'h2000, 1'b1, 1'b1, 32'h0000_0001, 32'h0000_0000);
        ev(16'h2000, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0000);
        wr(evgate_pkg::CTRL_OFS, 32'h0000_0001);
        ev(16'h2000, 1'b0, 1'b0, 32'h0000_0001, 32'h0000_0000);
        ev(16'h2000, 1'b1, 1'b1, 32'h0000_0000, 32'h0000_0000);
        // Sort handling sends the rejected pulse to the second spectrum
        wr(evgate_pkg::CTRL_OFS, 32'h0000_0007);
        ev(16'h4000, 1'b0, 1'b0, 32'h0000_0000, 32'h0000_0001);
        wr(evgate_pkg::BIN_ADDR_OFS, 32'h0000_4400);
        rchk(evgate_pkg::BIN_DATA_OFS, 32'h0000_0001, "sorted bin");
        // Sampling delay: short sees the early level, long sees the late one
        wr(evgate_pkg::CTRL_OFS, 32'h0000_0003);
        ev(16'h2000, 1'b1, 1'b0, 32'h0000_0001, 32'h0000_0000);
        wr(evgate_pkg::DELAY_OFS, 32'h0000_001E);
        ev(16'h2000, 1'b1, 1'b0, 32'h0000_0000, 32'h0000_0000);
        wr(evgate_pkg::DELAY_OFS, 32'h0000_0BB8);
        rchk(evgate_pkg::DELAY_OFS, 32'h0000_09C4, "delay clamp");
        // Filter mode select reaches its pin
        // shaping time is raised on the filter side, outside this block
        wr(evgate_pkg::CTRL_OFS, 32'h0000_0008);
        cmp("filter out", 32'h0000_0001, {31'h0000_0000, lfr_o});
        rchk(evgate_pkg::CTRL_OFS, 32'h0000_0008, "ctrl lfr");
        wrap_up();
    end
endmodule : testbench
